// ### hw/adf_pkg.sv
// package: register map, field positions and timing counts of the diagnostic flag block
//
// Contract
// - ref detect on, external ref selected, ref low or open: set ref-detect flag.
// - ref-detect flag set also raises the summary controller-error status bit.
// - converter fault checks act only while their enable bit is set; code gates only the flag, not the clamp or the coefficient hold.
// - filter overflow or underflow flags converter error, clamps result zeros or ones.
// - modulator bitstream same value for 20 samples flags converter error.
// - offset calibration outside 0x07FF..0xF7FF keeps offset register, flags converter error.
// - gain calibration filter overflow flags converter error, keeps gain register.
// - converter flag updates with the data register, cleared only by writing one.
// - positive and negative input range checks have independent enables.
// - enabled input over supply or under ground sets its input range flag.
// - ref monitor on: positive ref over supply or negative under ground sets flag.
// - range flags set only while enabled, cleared by writing one.
// - clock tally on: tally register increments once per 131 controller clocks.
// - tally wraps to zero after all-ones and continues counting.
`default_nettype none
package adf_pkg;
	// register byte offsets on the APB
	localparam logic [7:0] ADF_OFS_ERR_EN    = 8'h00;
	localparam logic [7:0] ADF_OFS_ERR       = 8'h04;
	localparam logic [7:0] ADF_OFS_STATUS    = 8'h08;
	localparam logic [7:0] ADF_OFS_DATA      = 8'h0c;
	localparam logic [7:0] ADF_OFS_OFFSET    = 8'h10;
	localparam logic [7:0] ADF_OFS_GAIN      = 8'h14;
	localparam logic [7:0] ADF_OFS_CLK_TALLY = 8'h18;

	// field positions: enable and flag register share bits 0..4, bit 5 is enable only, ADF_B_CTRL_ERR is the status bit
	localparam int ADF_B_REF_DET   = 0;
	localparam int ADF_B_ADC       = 1;
	localparam int ADF_B_POS_RANGE = 2;
	localparam int ADF_B_NEG_RANGE = 3;
	localparam int ADF_B_REF_RANGE = 4;
	localparam int ADF_B_CLK_TALLY = 5;
	localparam int ADF_B_CTRL_ERR  = 0;
	localparam int ADF_EN_W        = 6;
	localparam int ADF_FLAG_W      = 5;

	// reset values
	localparam logic [ADF_EN_W-1:0]   ADF_ERR_EN_RST = 6'h00;
	localparam logic [ADF_FLAG_W-1:0] ADF_ERR_RST    = 5'h00;
	localparam logic [15:0]           ADF_OFFSET_RST = 16'h8000;
	localparam logic [15:0]           ADF_GAIN_RST   = 16'h5555;

	// calibration coefficient limits, inclusive
	localparam logic [15:0] ADF_OFS_COEF_MIN = 16'h07ff;
	localparam logic [15:0] ADF_OFS_COEF_MAX = 16'hf7ff;

	// timing counts
	localparam int ADF_SAT_RUN    = 20;
	localparam int ADF_TALLY_DIV  = 131;

	// apb access phase
	typedef enum logic [1:0] {
		ADF_IDLE = 2'b00,
		ADF_WAIT = 2'b01,
		ADF_DONE = 2'b10
	} adf_apb_st_t;
endpackage : adf_pkg
`default_nettype wire

// ### hw/adf_sat_if.sv
// interface: modulator bitstream samples to the saturation detector and its hit back
`timescale 1ns/10ps
`default_nettype none
interface adf_sat_if;
	logic sample_en;	// one modulator sample this cycle
	logic bit_val;		// modulator output bit
	logic restart;		// conversion start, forget the running count
	logic sat_hit;		// one-cycle pulse: run of identical bits reached its limit

	modport mon (output sample_en, output bit_val, output restart, input sat_hit);
	modport det (input sample_en, input bit_val, input restart, output sat_hit);
endinterface : adf_sat_if
`default_nettype wire

// ### hw/adf_sat_detect.sv
// module: counts identical modulator bits and pulses once a saturating run is seen
`timescale 1ns/10ps
`default_nettype none
module adf_sat_detect
	import adf_pkg::*;
#(
	parameter int RUN_LEN = ADF_SAT_RUN	// identical samples that mean saturation
)(
	input  wire logic pclk,		// system clock
	input  wire logic presetn,	// asynchronous reset, active low
	adf_sat_if.det    sat		// sample stream in, hit out
);
	localparam int CW = $clog2(RUN_LEN + 1);
	localparam logic [CW-1:0] RUN_LAST = CW'(RUN_LEN);

	logic [CW-1:0] run_r;
	logic          last_r;
	logic          hit_r;

	// run length of equal bits; saturates at the limit so one run gives one pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_r  <= '0;
			last_r <= 1'b0;
		end
		else if (sat.restart)
		begin
			run_r  <= '0;
		end
		else if (sat.sample_en)
		begin
			last_r <= sat.bit_val;
			if (run_r == '0 || sat.bit_val != last_r)
				run_r <= CW'(1);
			else if (run_r != RUN_LAST)
				run_r <= run_r + CW'(1);
		end
	end

	// pulse on the sample that completes the run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hit_r <= 1'b0;
		else
			hit_r <= !sat.restart && sat.sample_en && run_r == RUN_LAST - CW'(1)
				&& sat.bit_val == last_r;
	end

	assign sat.sat_hit = hit_r;
endmodule // adf_sat_detect
`default_nettype wire

// ### hw/adf_diag_top.sv
// module: diagnostic error flags, converter data capture and clock tally behind an APB slave
`timescale 1ns/10ps
`default_nettype none
module adf_diag_top
	import adf_pkg::*;
#(
	parameter int DATA_W  = 16,		// conversion result width
	parameter int TALLY_W = 8,		// clock tally register width
	parameter int TALLY_DIV = ADF_TALLY_DIV	// controller clocks per tally step
)(
	input  wire logic              pclk,		// system clock
	input  wire logic              presetn,		// asynchronous reset, active low
	input  wire logic              psel,		// apb select
	input  wire logic              penable,		// apb access phase
	input  wire logic              pwrite,		// apb write
	input  wire logic [7:0]        paddr,		// apb byte address
	input  wire logic [31:0]       pwdata,		// apb write data
	output logic      [31:0]       prdata,		// apb read data
	output logic                   pready,		// apb ready
	output logic                   pslverr,		// apb error, unmapped address
	input  wire logic              mclk_en,		// one controller clock cycle
	input  wire logic              ext_ref_sel,	// external reference selected
	input  wire logic              ref_low,		// reference below threshold
	input  wire logic              ref_open,	// a reference input open
	input  wire logic              pos_ov,		// positive input above supply
	input  wire logic              pos_uv,		// positive input below ground
	input  wire logic              neg_ov,		// negative input above supply
	input  wire logic              neg_uv,		// negative input below ground
	input  wire logic              refp_ov,		// positive ref above supply
	input  wire logic              refm_uv,		// negative ref below ground
	input  wire logic              conv_start,	// conversion begins
	input  wire logic              filt_ovf,	// filter overflow this cycle
	input  wire logic              filt_unf,	// filter underflow this cycle
	input  wire logic              mod_sample,	// modulator sample strobe
	input  wire logic              mod_bit,		// modulator bitstream
	input  wire logic              conv_done,	// result ready, data register loads
	input  wire logic [DATA_W-1:0] conv_result,	// raw filter result
	input  wire logic              gcal_busy,	// gain calibration running
	input  wire logic              ocal_done,	// offset calibration finished
	input  wire logic [15:0]       ocal_coef,	// offset coefficient found
	input  wire logic              gcal_done,	// gain calibration finished
	input  wire logic [15:0]       gcal_coef,	// gain coefficient found
	output logic                   controller_err,	// summary controller error
	output logic [ADF_FLAG_W-1:0]  err_flags	// sticky error flags
);
	localparam int DW = $clog2(TALLY_DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(TALLY_DIV - 1);

	// set wins over a coinciding write-one-to-clear
	function automatic logic sticky(input logic cur, input logic clr, input logic set);
		sticky = set | (cur & ~clr);
	endfunction

	adf_apb_st_t            st_r;
	logic                   pready_r;
	logic                   pslverr_r;
	logic [31:0]            prdata_r;
	logic [ADF_EN_W-1:0]    err_en_r;
	logic [ADF_FLAG_W-1:0]  err_r;
	logic [DATA_W-1:0]      data_r;
	logic [15:0]            offset_r;
	logic [15:0]            gain_r;
	logic [TALLY_W-1:0]     tally_r;
	logic [DW-1:0]          div_r;
	logic                   pend_r;
	logic                   ovf_seen_r;
	logic                   unf_seen_r;
	logic                   gcal_ovf_r;

	logic                   xfer;
	logic                   wr;
	logic                   mapped;
	logic [31:0]            rd_mux;
	logic [ADF_FLAG_W-1:0]  w1c;
	logic [ADF_FLAG_W-1:0]  set_ev;
	logic                   ocal_bad;
	logic                   adc_on;
	logic                   conv_fault;

	adf_sat_if sat_if ();

	// saturation run detection lives in its own module
	adf_sat_detect #(
		.RUN_LEN (ADF_SAT_RUN)
	) u_sat (
		.pclk    (pclk),
		.presetn (presetn),
		.sat     (sat_if.det)
	);

	assign sat_if.sample_en = mod_sample;
	assign sat_if.bit_val   = mod_bit;
	assign sat_if.restart   = conv_start;

	// apb decode; the transfer completes at the edge where pready is high
	assign xfer = psel && penable && pready_r;
	assign wr   = xfer && pwrite && !pslverr_r;

	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADF_OFS_ERR_EN:    rd_mux[ADF_EN_W-1:0]   = err_en_r;
			ADF_OFS_ERR:       rd_mux[ADF_FLAG_W-1:0] = err_r;
			ADF_OFS_STATUS:    rd_mux[ADF_B_CTRL_ERR] = err_r[ADF_B_REF_DET];
			ADF_OFS_DATA:      rd_mux[DATA_W-1:0]     = data_r;
			ADF_OFS_OFFSET:    rd_mux[15:0]           = offset_r;
			ADF_OFS_GAIN:      rd_mux[15:0]           = gain_r;
			ADF_OFS_CLK_TALLY: rd_mux[TALLY_W-1:0]    = tally_r;
			default:           mapped = 1'b0;
		endcase
	end

	// one wait state: answer is prepared in the cycle after the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r      <= ADF_IDLE;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
		else
		begin
			case (st_r)
				ADF_IDLE:
				begin
					if (psel && penable)
					begin
						st_r      <= ADF_WAIT;
						pready_r  <= 1'b1;
						pslverr_r <= !mapped;
						prdata_r  <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
					end
				end
				ADF_WAIT:
				begin
					st_r      <= ADF_DONE;
					pready_r  <= 1'b0;
					pslverr_r <= 1'b0;
				end
				ADF_DONE:
					st_r <= ADF_IDLE;
				default:
				begin
					st_r     <= ADF_IDLE;
					pready_r <= 1'b0;
				end
			endcase
		end
	end

	// enable register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_en_r <= ADF_ERR_EN_RST;
		else if (wr && paddr == ADF_OFS_ERR_EN)
			err_en_r <= pwdata[ADF_EN_W-1:0];
	end

	// set events, each gated by its own enable
	assign adc_on     = err_en_r[ADF_B_ADC];
	assign ocal_bad   = ocal_coef < ADF_OFS_COEF_MIN || ocal_coef > ADF_OFS_COEF_MAX;
	assign conv_fault = filt_ovf || filt_unf || sat_if.sat_hit;

	always_comb
	begin
		set_ev = '0;
		set_ev[ADF_B_REF_DET] = err_en_r[ADF_B_REF_DET] && ext_ref_sel
			&& (ref_low || ref_open);
		set_ev[ADF_B_ADC] = adc_on && ((conv_done && (pend_r || conv_fault))
			|| (ocal_done && ocal_bad)
			|| (gcal_done && (gcal_ovf_r || filt_ovf)));
		set_ev[ADF_B_POS_RANGE] = err_en_r[ADF_B_POS_RANGE] && (pos_ov || pos_uv);
		set_ev[ADF_B_NEG_RANGE] = err_en_r[ADF_B_NEG_RANGE] && (neg_ov || neg_uv);
		set_ev[ADF_B_REF_RANGE] = err_en_r[ADF_B_REF_RANGE] && (refp_ov || refm_uv);
	end

	assign w1c = (wr && paddr == ADF_OFS_ERR) ? pwdata[ADF_FLAG_W-1:0] : '0;

	// sticky flags; the software clear never beats a new event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_r <= ADF_ERR_RST;
		else
			for (int i = 0; i < ADF_FLAG_W; i++)
				err_r[i] <= sticky(err_r[i], w1c[i], set_ev[i]);
	end

	// faults seen during a conversion wait for the data register load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_r <= 1'b0;
		else if (conv_done || conv_start)
			pend_r <= 1'b0;
		else if (adc_on && conv_fault)
			pend_r <= 1'b1;
	end

	// filter range excursions decide the clamp, independent of the flag enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_seen_r <= 1'b0;
			unf_seen_r <= 1'b0;
		end
		else if (conv_done || conv_start)
		begin
			ovf_seen_r <= 1'b0;
			unf_seen_r <= 1'b0;
		end
		else
		begin
			ovf_seen_r <= ovf_seen_r || filt_ovf;
			unf_seen_r <= unf_seen_r || filt_unf;
		end
	end

	// data register, clamped on a filter range fault
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_r <= '0;
		else if (conv_done)
		begin
			if (ovf_seen_r || filt_ovf)
				data_r <= '0;
			else if (unf_seen_r || filt_unf)
				data_r <= '1;
			else
				data_r <= conv_result;
		end
	end

	// overflow during a gain calibration is remembered until it finishes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gcal_ovf_r <= 1'b0;
		else if (gcal_done || !gcal_busy)
			gcal_ovf_r <= 1'b0;
		else if (filt_ovf)
			gcal_ovf_r <= 1'b1;
	end

	// offset coefficient: a bad calibration result is dropped, software may still write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			offset_r <= ADF_OFFSET_RST;
		else if (ocal_done)
		begin
			if (!ocal_bad)
				offset_r <= ocal_coef;
		end
		else if (wr && paddr == ADF_OFS_OFFSET)
			offset_r <= pwdata[15:0];
	end

	// gain coefficient: kept when the calibration overflowed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gain_r <= ADF_GAIN_RST;
		else if (gcal_done)
		begin
			if (!(gcal_ovf_r || filt_ovf))
				gain_r <= gcal_coef;
		end
		else if (wr && paddr == ADF_OFS_GAIN)
			gain_r <= pwdata[15:0];
	end

	// controller clock divider; restarts from zero whenever the tally is switched off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_r <= '0;
		else if (!err_en_r[ADF_B_CLK_TALLY])
			div_r <= '0;
		else if (mclk_en)
			div_r <= (div_r == DIV_LAST) ? '0 : div_r + DW'(1);
	end

	// tally keeps its value when disabled so software can read it afterwards
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tally_r <= '0;
		else if (err_en_r[ADF_B_CLK_TALLY] && mclk_en && div_r == DIV_LAST)
			tally_r <= tally_r + TALLY_W'(1);
	end

	// flag outputs mirror the flag register flops
	assign controller_err = err_r[ADF_B_REF_DET];
	assign err_flags      = err_r;
	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
endmodule // adf_diag_top
`default_nettype wire

// ### verification/adf_diag_assertions.sv
// checker: port-level properties of the diagnostic flag block
`timescale 1ns/10ps
`default_nettype none
module adf_diag_assertions
	import adf_pkg::*;
(
	input wire logic                  pclk,           // clock
	input wire logic                  presetn,        // reset, active low
	input wire logic                  psel,           // apb select
	input wire logic                  penable,        // apb access
	input wire logic                  pwrite,         // apb write
	input wire logic [7:0]            paddr,          // apb address
	input wire logic [31:0]           pwdata,         // apb write data
	input wire logic                  pready,         // apb ready
	input wire logic                  pslverr,        // apb error
	input wire logic                  ext_ref_sel,    // external ref chosen
	input wire logic                  ref_low,        // ref under threshold
	input wire logic                  ref_open,       // ref input open
	input wire logic                  pos_ov,         // positive input high
	input wire logic                  pos_uv,         // positive input low
	input wire logic                  conv_done,      // data register load
	input wire logic                  ocal_done,      // offset cal end
	input wire logic                  gcal_done,      // gain cal end
	input wire logic                  controller_err, // summary error
	input wire logic [ADF_FLAG_W-1:0] err_flags       // sticky flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// completed write to the flag register
	logic wr_err;
	assign wr_err = psel && penable && pready && pwrite && paddr == ADF_OFS_ERR;

	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence

	// depth two on causes tolerates one input register stage
	property p_answer; s_setup |-> ##[0:4] pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err_resp; pslverr |-> pready && psel && penable; endproperty
	property p_ctrl; controller_err == err_flags[ADF_B_REF_DET]; endproperty
	property p_sticky; |($past(err_flags) & ~err_flags) |-> $past(wr_err); endproperty
	property p_clear_bits;
		($past(err_flags) & ~err_flags & ~$past(pwdata[ADF_FLAG_W-1:0])) == 5'h00;
	endproperty
	property p_refdet_cause;
		$rose(err_flags[ADF_B_REF_DET]) |-> $past(ext_ref_sel && (ref_low || ref_open))
			|| $past(ext_ref_sel && (ref_low || ref_open), 2);
	endproperty
	property p_adc_cause;
		$rose(err_flags[ADF_B_ADC]) |-> $past(conv_done || ocal_done || gcal_done)
			|| $past(conv_done || ocal_done || gcal_done, 2);
	endproperty
	property p_pos_cause;
		$rose(err_flags[ADF_B_POS_RANGE]) |-> $past(pos_ov || pos_uv) || $past(pos_ov || pos_uv, 2);
	endproperty

	a_answer: assert property (p_answer) else $error("apb answer late");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	a_err_resp: assert property (p_err_resp) else $error("pslverr outside access");
	a_ctrl: assert property (p_ctrl) else $error("summary error wrong");
	a_sticky: assert property (p_sticky) else $error("flag dropped unwritten");
	a_clear_bits: assert property (p_clear_bits) else $error("wrong flag cleared");
	a_refdet_cause: assert property (p_refdet_cause) else $error("refdet flag no cause");
	a_adc_cause: assert property (p_adc_cause) else $error("adc flag off update");
	a_pos_cause: assert property (p_pos_cause) else $error("pos range no cause");
endmodule // adf_diag_assertions

bind adf_diag_top adf_diag_assertions adf_diag_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.ext_ref_sel(ext_ref_sel), .ref_low(ref_low), .ref_open(ref_open), .pos_ov(pos_ov),
	.pos_uv(pos_uv), .conv_done(conv_done), .ocal_done(ocal_done), .gcal_done(gcal_done),
	.controller_err(controller_err), .err_flags(err_flags));
`default_nettype wire

// ### verification/tb_top.sv
// testbench: register-level tests of the diagnostic flag block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import adf_pkg::*;
;
	localparam int TDIV = 4; // short tally divider keeps the run brief
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic mclk_en = 1'b0, ext_ref_sel = 1'b0, ref_low = 1'b0, ref_open = 1'b0;
	logic conv_start = 1'b0, filt_ovf = 1'b0, filt_unf = 1'b0, mod_sample = 1'b0;
	logic mod_bit = 1'b0, conv_done = 1'b0, gcal_busy = 1'b0, ocal_done = 1'b0;
	logic gcal_done = 1'b0, se, bad, pready, pslverr, controller_err;
	logic [5:0] flt = 6'h00; // {refm_uv, refp_ov, neg_uv, neg_ov, pos_uv, pos_ov}
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic [15:0] conv_result = 16'h0, ocal_coef = 16'h0, gcal_coef = 16'h0, eo;
	logic [15:0] oc [4] = '{16'h07fe, 16'h07ff, 16'hf7ff, 16'hf800};
	logic [ADF_FLAG_W-1:0] err_flags;
	int err_total = 0, check_count = 0, cyc_n = 0, b;

	adf_diag_top #(.TALLY_DIV(TDIV)) adf_diag_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mclk_en(mclk_en), .ext_ref_sel(ext_ref_sel), .ref_low(ref_low), .ref_open(ref_open),
		.pos_ov(flt[0]), .pos_uv(flt[1]), .neg_ov(flt[2]), .neg_uv(flt[3]), .refp_ov(flt[4]),
		.refm_uv(flt[5]), .conv_start(conv_start), .filt_ovf(filt_ovf), .filt_unf(filt_unf),
		.mod_sample(mod_sample), .mod_bit(mod_bit), .conv_done(conv_done),
		.conv_result(conv_result), .gcal_busy(gcal_busy), .ocal_done(ocal_done),
		.ocal_coef(ocal_coef), .gcal_done(gcal_done), .gcal_coef(gcal_coef),
		.controller_err(controller_err), .err_flags(err_flags));

	// clock, 40 ns period
	initial
	begin
		forever #20 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard, run needs under two thousand cycles
	always @(posedge pclk)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one apb transfer, held until pready seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(pready, 32'h1, "apb ready");
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask

	task automatic fault(input logic [5:0] v);
		@(posedge pclk);
		flt <= v;
		@(posedge pclk);
		flt <= 6'h00;
		repeat (2) @(posedge pclk);
	endtask

	task automatic mclk(input int n);
		@(posedge pclk);
		mclk_en <= 1'b1;
		repeat (n) @(posedge pclk);
		mclk_en <= 1'b0;
	endtask

	// one conversion with chosen filter faults and n identical modulator bits
	task automatic conv(input logic en, o, u, input int n, input logic [31:0] ed);
		apb(1'b1, ADF_OFS_ERR_EN, {30'h0, en, 1'b0});
		@(posedge pclk);
		conv_start <= 1'b1;
		@(posedge pclk);
		conv_start <= 1'b0;
		filt_ovf <= o;
		filt_unf <= u;
		mod_bit <= 1'b1;
		mod_sample <= n > 0;
		repeat (n > 0 ? n : 1) @(posedge pclk);
		filt_ovf <= 1'b0;
		filt_unf <= 1'b0;
		mod_sample <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(err_flags[ADF_B_ADC], 32'h0, "adc early");
		conv_done <= 1'b1;
		conv_result <= 16'h1234;
		@(posedge pclk);
		conv_done <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(err_flags[ADF_B_ADC], en & (o | u | n >= ADF_SAT_RUN), "adc flag");
		rchk(ADF_OFS_DATA, ed, "data");
		apb(1'b1, ADF_OFS_ERR, 32'h2);
	endtask

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rchk(ADF_OFS_ERR_EN, 32'h0, "en rst");
		rchk(ADF_OFS_OFFSET, 32'h8000, "ofs rst");
		rchk(ADF_OFS_GAIN, 32'h5555, "gain rst");
		apb(1'b1, ADF_OFS_DATA, 32'hffff);
		rchk(ADF_OFS_DATA, 32'h0, "ro data");
		apb(1'b0, 8'h1c, 32'h0);
		chk(se, 32'h1, "unmapped");
		$display("test registers done");
		// reference detect, disabled first
		@(posedge pclk);
		ext_ref_sel <= 1'b1;
		ref_low <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(err_flags, 32'h0, "refdet off");
		apb(1'b1, ADF_OFS_ERR_EN, 32'h1);
		// enable lands at the completion edge, so the fault must stand one edge longer
		@(posedge pclk);
		ref_low <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(controller_err, 32'h1, "ctrl err");
		rchk(ADF_OFS_STATUS, 32'h1, "status");
		apb(1'b1, ADF_OFS_ERR, 32'h1);
		rchk(ADF_OFS_ERR, 32'h0, "refdet w1c");
		ext_ref_sel <= 1'b0;
		ref_open <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(err_flags, 32'h0, "internal ref");
		ext_ref_sel <= 1'b1;
		@(posedge pclk);
		ext_ref_sel <= 1'b0;
		ref_open <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(err_flags, 32'h1, "ref open");
		apb(1'b1, ADF_OFS_ERR, 32'h1);
		$display("test reference detect done");
		// each range fault, first with its own check off
		for (int i = 0; i < 6; i++)
		begin
			b = 2 + i / 2;
			apb(1'b1, ADF_OFS_ERR_EN, 32'h1f ^ (32'h1 << b));
			fault(6'h01 << i);
			chk(err_flags, 32'h0, "range off");
			apb(1'b1, ADF_OFS_ERR_EN, 32'h1 << b);
			fault(6'h01 << i);
			chk(err_flags, 32'h1 << b, "range on");
			apb(1'b1, ADF_OFS_ERR, 32'h1 << b);
			@(posedge pclk);
			chk(err_flags, 32'h0, "range w1c");
		end
		$display("test range monitors done");
		conv(1'b1, 1'b1, 1'b0, 0, 32'h0000);
		conv(1'b1, 1'b0, 1'b1, 0, 32'hffff);
		conv(1'b1, 1'b1, 1'b1, 0, 32'h0000);
		conv(1'b1, 1'b0, 1'b0, 0, 32'h1234);
		conv(1'b0, 1'b1, 1'b0, 0, 32'h0000);
		conv(1'b1, 1'b0, 1'b0, 19, 32'h1234);
		conv(1'b1, 1'b0, 1'b0, 20, 32'h1234);
		$display("test conversions done");
		// offset limits, both sides of each bound
		eo = ADF_OFFSET_RST;
		foreach (oc[i])
		begin
			@(posedge pclk);
			ocal_done <= 1'b1;
			ocal_coef <= oc[i];
			@(posedge pclk);
			ocal_done <= 1'b0;
			repeat (2) @(posedge pclk);
			bad = oc[i] < ADF_OFS_COEF_MIN || oc[i] > ADF_OFS_COEF_MAX;
			eo = bad ? eo : oc[i];
			chk(err_flags[ADF_B_ADC], bad, "ocal flag");
			rchk(ADF_OFS_OFFSET, {16'h0, eo}, "offset");
			apb(1'b1, ADF_OFS_ERR, 32'h2);
		end
		// gain calibration, with and without filter overflow
		for (int i = 0; i < 2; i++)
		begin
			@(posedge pclk);
			gcal_busy <= 1'b1;
			filt_ovf <= i == 0;
			@(posedge pclk);
			filt_ovf <= 1'b0;
			gcal_done <= 1'b1;
			gcal_coef <= 16'h600a;
			@(posedge pclk);
			gcal_done <= 1'b0;
			gcal_busy <= 1'b0;
			repeat (2) @(posedge pclk);
			chk(err_flags[ADF_B_ADC], i == 0, "gcal flag");
			rchk(ADF_OFS_GAIN, i == 0 ? 32'h5555 : 32'h600a, "gain");
			apb(1'b1, ADF_OFS_ERR, 32'h2);
		end
		$display("test calibration done");
		apb(1'b1, ADF_OFS_ERR_EN, 32'h0);
		mclk(TDIV);
		rchk(ADF_OFS_CLK_TALLY, 32'h0, "tally off");
		apb(1'b1, ADF_OFS_ERR_EN, 32'h20);
		mclk(TDIV - 1);
		rchk(ADF_OFS_CLK_TALLY, 32'h0, "tally early");
		mclk(1);
		rchk(ADF_OFS_CLK_TALLY, 32'h1, "tally step");
		mclk(255 * TDIV);
		rchk(ADF_OFS_CLK_TALLY, 32'h0, "tally wrap");
		mclk(TDIV);
		rchk(ADF_OFS_CLK_TALLY, 32'h1, "tally on");
		$display("test clock tally done");
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
